// file: src/mie_pkg.sv
// package for the misc instruction execute block
package mie_pkg;
	localparam logic [7:0] OP_IDLE = 8'h00;
	localparam logic [3:0] OP_PORT_HI = 4'h2;
	localparam logic [1:0] OP_PORT_MID = 2'h1;
	localparam logic [7:0] OP_SET_CTL = 8'h2c;
	localparam logic [3:0] OP_CLR_CTL_HI = 4'h3;
	localparam logic [7:0] OP_CLR_CTL = 8'h3c;
	localparam logic [7:0] OP_TIMER_LOAD = 8'hfb;
	localparam logic [7:0] OP_STOP = 8'hf6;
	localparam int NUM_PORTS = 16;
	localparam logic [3:0] CTL_RESET = 4'h0;
	localparam logic [3:0] PORT_RESET = 4'hf;
	localparam logic [3:0] AUX_CORRUPT = 4'h0;
	// register offsets of the interrupt group, plus control and timer readback
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CLEAR = 4'h1;
	localparam logic [3:0] ADDR_ENABLE = 4'h2;
	localparam logic [3:0] ADDR_CTL = 4'h3;
	localparam logic [3:0] ADDR_TIMER = 4'h4;
	localparam int EV_OVF = 0;
	localparam int EV_STOP = 1;
	localparam int EV_BITS = 2;

	typedef enum logic [1:0] {
		ST_FETCH = 2'b00,
		ST_IMM = 2'b01,
		ST_STOPPED = 2'b10
	} mie_state_e;

	typedef struct packed {
		logic valid;
		logic [7:0] byte_v;
	} mie_fetch_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mie_bus_s;
endpackage

// file: src/mie_core.sv
// execute logic for port-bit, control, timer-load, stop and idle instructions
`timescale 1ns/10ps
// Overview of operation
// - the clear-port-bit opcode 0010 01bb drives the indexed port bit low, updates the zero flag and spoils the auxiliary register.
// - the set-control-bits opcode 0010 1100 ORs the following 4-bit mask into the control register.
// - the clear-control-bits opcode clears the masked control bits, keeps the rest and updates the zero flag.
// - opcode 1111 1011 loads the timer with auxiliary as upper and work as lower nibble and clears the overflow flag.
// - opcode 1111 0110 stops instruction fetch and execution unless every standby port bit reads 0.
// - the all-zero opcode takes one machine cycle and changes nothing.
// - port-bit instructions pick the port from the pointer low nibble and the bit from the opcode field.
module mie_core (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// instruction stream from program memory
	input wire mie_pkg::mie_fetch_s fetch,
	output logic fetch_ready,
	// core state
	input wire logic [3:0] pointer_low_nibble,
	input wire logic [3:0] work_register,
	input wire logic [3:0] aux_in,
	input wire logic timer_overflow,
	input wire logic [3:0] standby_release_port,
	// results
	output logic [3:0] aux_out,
	output logic aux_we,
	output logic zero_flag,
	output logic [3:0] control_register,
	output logic [7:0] count_value_register,
	output logic timer_load,
	output logic timer_overflow_flag,
	output logic stopped,
	output logic [mie_pkg::NUM_PORTS*4-1:0] port_out,
	// register port
	input wire mie_pkg::mie_bus_s bus,
	output logic [7:0] rdata,
	output logic irq
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// both stages reset low, so a stop right after reset stays gated until the pins are seen
	logic [3:0] sb_meta_r, sb_sync_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sb_meta_r <= 4'h0;
			sb_sync_r <= 4'h0;
		end else if (clk_en) begin
			sb_meta_r <= standby_release_port;
			sb_sync_r <= sb_meta_r;
		end
	end

	// ------------------------------------------------------------
	// decode and execute
	// ------------------------------------------------------------
	mie_pkg::mie_state_e state_r, state_nxt;
	logic [7:0] op_r, op_nxt;
	logic [3:0] ctl_r, ctl_nxt;
	logic zf_r, zf_nxt;
	logic [7:0] tm_r, tm_nxt;
	logic tmf_r, tmf_nxt;
	logic [3:0] aux_r, aux_nxt;
	logic aux_we_r, aux_we_nxt;
	logic tld_r, tld_nxt;
	logic [mie_pkg::NUM_PORTS*4-1:0] port_r, port_nxt;
	logic [mie_pkg::EV_BITS-1:0] stat_r, stat_nxt, en_r, en_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [3:0] port_sel;
	logic [3:0] new_nib;
	logic ev_stop;

	assign fetch_ready = (state_r != mie_pkg::ST_STOPPED);

	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		ctl_nxt = ctl_r;
		zf_nxt = zf_r;
		tm_nxt = tm_r;
		tmf_nxt = tmf_r;
		aux_nxt = aux_r;
		aux_we_nxt = 1'b0;
		tld_nxt = 1'b0;
		port_nxt = port_r;
		ev_stop = 1'b0;
		port_sel = port_r[pointer_low_nibble*4 +: 4];
		new_nib = port_sel;
		if (timer_overflow)
			tmf_nxt = 1'b1;
		if (fetch.valid && fetch_ready) begin
			case (state_r)
				mie_pkg::ST_FETCH: begin
					op_nxt = fetch.byte_v;
					if (fetch.byte_v == mie_pkg::OP_SET_CTL ||
						fetch.byte_v == mie_pkg::OP_CLR_CTL) begin
						state_nxt = mie_pkg::ST_IMM;
					end else if (fetch.byte_v[7:4] == mie_pkg::OP_PORT_HI &&
						fetch.byte_v[3:2] == mie_pkg::OP_PORT_MID) begin
						new_nib = port_sel & ~(4'h1 << fetch.byte_v[1:0]);
						port_nxt[pointer_low_nibble*4 +: 4] = new_nib;
						zf_nxt = (new_nib == 4'h0);
						// aux is spoiled on purpose; nothing downstream may rely on it
						aux_nxt = mie_pkg::AUX_CORRUPT;
						aux_we_nxt = 1'b1;
					end else if (fetch.byte_v == mie_pkg::OP_TIMER_LOAD) begin
						tm_nxt = {aux_in, work_register};
						tld_nxt = 1'b1;
						tmf_nxt = 1'b0;
					end else if (fetch.byte_v == mie_pkg::OP_STOP) begin
						if (sb_sync_r != 4'h0) begin
							state_nxt = mie_pkg::ST_STOPPED;
							ev_stop = 1'b1;
						end
					end
					// idle opcode and others fall through untouched
				end
				mie_pkg::ST_IMM: begin
					state_nxt = mie_pkg::ST_FETCH;
					if (op_r == mie_pkg::OP_SET_CTL) begin
						ctl_nxt = ctl_r | fetch.byte_v[3:0];
					end else begin
						ctl_nxt = ctl_r & ~fetch.byte_v[3:0];
						zf_nxt = ((ctl_r & ~fetch.byte_v[3:0]) == 4'h0);
					end
				end
				default: state_nxt = mie_pkg::ST_FETCH;
			endcase
		end
	end

	// ------------------------------------------------------------
	// interrupt registers and bus
	// ------------------------------------------------------------
	always_comb begin
		stat_nxt = stat_r;
		en_nxt = en_r;
		rdata_nxt = 8'h00;
		if (bus.wr && bus.addr == mie_pkg::ADDR_CLEAR)
			stat_nxt = stat_r & ~bus.wdata[mie_pkg::EV_BITS-1:0];
		if (bus.wr && bus.addr == mie_pkg::ADDR_ENABLE)
			en_nxt = bus.wdata[mie_pkg::EV_BITS-1:0];
		// set wins over a clear in the same cycle
		if (timer_overflow)
			stat_nxt[mie_pkg::EV_OVF] = 1'b1;
		if (ev_stop)
			stat_nxt[mie_pkg::EV_STOP] = 1'b1;
		if (bus.rd) begin
			case (bus.addr)
				mie_pkg::ADDR_STATUS: rdata_nxt = {6'h00, stat_r};
				mie_pkg::ADDR_ENABLE: rdata_nxt = {6'h00, en_r};
				mie_pkg::ADDR_CTL: rdata_nxt = {4'h0, ctl_r};
				mie_pkg::ADDR_TIMER: rdata_nxt = tm_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= mie_pkg::ST_FETCH;
			op_r <= 8'h00;
			ctl_r <= mie_pkg::CTL_RESET;
			zf_r <= 1'b0;
			tm_r <= 8'h00;
			tmf_r <= 1'b0;
			aux_r <= 4'h0;
			aux_we_r <= 1'b0;
			tld_r <= 1'b0;
			port_r <= {mie_pkg::NUM_PORTS{mie_pkg::PORT_RESET}};
			stat_r <= '0;
			en_r <= '0;
			rdata_r <= 8'h00;
		end else if (clk_en) begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			ctl_r <= ctl_nxt;
			zf_r <= zf_nxt;
			tm_r <= tm_nxt;
			tmf_r <= tmf_nxt;
			aux_r <= aux_nxt;
			aux_we_r <= aux_we_nxt;
			tld_r <= tld_nxt;
			port_r <= port_nxt;
			stat_r <= stat_nxt;
			en_r <= en_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign aux_out = aux_r;
	assign aux_we = aux_we_r;
	assign zero_flag = zf_r;
	assign control_register = ctl_r;
	assign count_value_register = tm_r;
	assign timer_load = tld_r;
	assign timer_overflow_flag = tmf_r;
	assign stopped = (state_r == mie_pkg::ST_STOPPED);
	assign port_out = port_r;
	assign rdata = rdata_r;
	assign irq = |(stat_r & en_r);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_tload;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && fetch.valid && fetch_ready && state_r == mie_pkg::ST_FETCH &&
			fetch.byte_v == mie_pkg::OP_TIMER_LOAD) |=>
			(count_value_register == $past({aux_in, work_register}) && !timer_overflow_flag);
	endproperty
	a_tload: assert property (p_tload) else $error("timer load wrong");

	property p_stop_gate;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && fetch.valid && fetch_ready && state_r == mie_pkg::ST_FETCH &&
			fetch.byte_v == mie_pkg::OP_STOP && sb_sync_r == 4'h0) |=> !stopped;
	endproperty
	a_stop_gate: assert property (p_stop_gate) else $error("stop not gated");

	property p_stop;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && fetch.valid && fetch_ready && state_r == mie_pkg::ST_FETCH &&
			fetch.byte_v == mie_pkg::OP_STOP && sb_sync_r != 4'h0) |=> stopped;
	endproperty
	a_stop: assert property (p_stop) else $error("stop missed");

	property p_idle;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && fetch.valid && fetch_ready && state_r == mie_pkg::ST_FETCH &&
			fetch.byte_v == mie_pkg::OP_IDLE && !timer_overflow) |=>
			($stable(control_register) && $stable(port_out) && $stable(zero_flag) &&
			$stable(count_value_register) && !stopped);
	endproperty
	a_idle: assert property (p_idle) else $error("idle changed state");

	property p_setctl;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && fetch.valid && state_r == mie_pkg::ST_IMM && op_r == mie_pkg::OP_SET_CTL)
			|=> control_register == ($past(control_register) | $past(fetch.byte_v[3:0]));
	endproperty
	a_setctl: assert property (p_setctl) else $error("set control wrong");

	property p_clrctl;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && fetch.valid && state_r == mie_pkg::ST_IMM && op_r == mie_pkg::OP_CLR_CTL)
			|=> (control_register == ($past(control_register) & ~$past(fetch.byte_v[3:0]))
			&& zero_flag == (control_register == 4'h0));
	endproperty
	a_clrctl: assert property (p_clrctl) else $error("clear control wrong");

	property p_portbit;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && fetch.valid && fetch_ready && state_r == mie_pkg::ST_FETCH &&
			fetch.byte_v[7:2] == {mie_pkg::OP_PORT_HI, mie_pkg::OP_PORT_MID}) |=>
			(port_out[$past(pointer_low_nibble)*4 + $past(fetch.byte_v[1:0])] == 1'b0 && aux_we);
	endproperty
	a_portbit: assert property (p_portbit) else $error("port bit not cleared");

	property p_ovf_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && timer_overflow && !(fetch.valid && fetch_ready &&
			state_r == mie_pkg::ST_FETCH && fetch.byte_v == mie_pkg::OP_TIMER_LOAD))
			|=> timer_overflow_flag;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag not set");

	property p_portsel;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && fetch.valid && fetch_ready && state_r == mie_pkg::ST_FETCH &&
			fetch.byte_v[7:2] == {mie_pkg::OP_PORT_HI, mie_pkg::OP_PORT_MID}) |=>
			zero_flag == (port_out[$past(pointer_low_nibble)*4 +: 4] == 4'h0);
	endproperty
	a_portsel: assert property (p_portsel) else $error("zero flag wrong");

	property p_ovf_clear;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && timer_overflow && fetch.valid && fetch_ready &&
			state_r == mie_pkg::ST_FETCH && fetch.byte_v == mie_pkg::OP_TIMER_LOAD)
			|=> (!timer_overflow_flag && timer_load);
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow beat load clear");

	// stop has no wake path here: only reset brings the core back
	property p_stop_hold;
		@(posedge core_clk) disable iff (!rst_n)
		stopped |=> (stopped && !fetch_ready);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop was left");

	// state must not move while the enable is low
	property p_freeze;
		@(posedge core_clk) disable iff (!rst_n)
		!clk_en |=> ($stable(control_register) && $stable(port_out) &&
			$stable(count_value_register) && $stable(stopped) && $stable(zero_flag));
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	property p_aux;
		@(posedge core_clk) disable iff (!rst_n)
		aux_we |-> aux_out == mie_pkg::AUX_CORRUPT;
	endproperty
	a_aux: assert property (p_aux) else $error("aux write value wrong");

	c_stop: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(stopped));
	c_tload: cover property (@(posedge core_clk) disable iff (!rst_n) timer_load);
	c_imm: cover property (@(posedge core_clk) disable iff (!rst_n) state_r == mie_pkg::ST_IMM);
	c_irq: cover property (@(posedge core_clk) disable iff (!rst_n) irq);
	c_portclr: cover property (@(posedge core_clk) disable iff (!rst_n) aux_we);
endmodule

// file: sim/mie_prog_mem.sv
// program memory model feeding opcode bytes to the execute block
`timescale 1ns/10ps
module mie_prog_mem (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// fetch handshake
	input wire logic clk_en,
	input wire logic fetch_ready,
	input wire logic slow,
	output mie_pkg::mie_fetch_s fetch
);
	logic [7:0] rom[$];
	logic taken;
	assign taken = fetch.valid & fetch_ready & clk_en;
	task automatic load(input logic [7:0] b);
		rom.push_back(b);
	endtask
	// ----------------------------------------
	// byte delivery
	// ----------------------------------------
	// slow inserts an idle cycle after each byte; an idle byte lane toggles so no
	// stale opcode can pass for a real one
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch <= '0;
		end else if (taken || !fetch.valid) begin
			if (rom.size() != 0 && !(slow && taken)) begin
				fetch.valid <= 1'b1;
				fetch.byte_v <= rom.pop_front();
			end else begin
				fetch.valid <= 1'b0;
				fetch.byte_v <= ~fetch.byte_v;
			end
		end
	end
endmodule

// file: sim/mie_core_tb_top.sv
// self-checking testbench for the misc instruction execute block
`timescale 1ns/10ps
module mie_core_tb_top;
	logic core_clk;
	logic rst_n;
	logic clk_en;
	logic timer_overflow;
	logic slow;
	logic [3:0] pointer_low_nibble;
	logic [3:0] work_register;
	logic [3:0] aux_in;
	logic [3:0] standby_release_port;
	mie_pkg::mie_fetch_s fetch;
	mie_pkg::mie_bus_s bus;
	logic fetch_ready;
	logic aux_we;
	logic zero_flag;
	logic timer_load;
	logic timer_overflow_flag;
	logic stopped;
	logic irq;
	logic [3:0] aux_out;
	logic [3:0] control_register;
	logic [7:0] count_value_register;
	logic [7:0] rdata;
	logic [mie_pkg::NUM_PORTS*4-1:0] port_out;
	logic [63:0] exp_port;
	logic [3:0] pl[3] = '{4'h5, 4'h0, 4'hf};
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int n_aux_we = 0;
	int n_tld = 0;

	mie_prog_mem u_mem (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.fetch_ready(fetch_ready), .slow(slow), .fetch(fetch));
	mie_core DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .fetch(fetch),
		.fetch_ready(fetch_ready), .pointer_low_nibble(pointer_low_nibble),
		.work_register(work_register), .aux_in(aux_in), .timer_overflow(timer_overflow),
		.standby_release_port(standby_release_port), .aux_out(aux_out), .aux_we(aux_we),
		.zero_flag(zero_flag), .control_register(control_register),
		.count_value_register(count_value_register), .timer_load(timer_load),
		.timer_overflow_flag(timer_overflow_flag), .stopped(stopped), .port_out(port_out),
		.bus(bus), .rdata(rdata), .irq(irq));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// bounded wait: a stopped core never drains, so the limit ends the wait
	task automatic drain;
		for (int k = 0; k < 40 && (u_mem.rom.size() != 0 || fetch.valid); k++)
			tick(1);
		tick(2);
	endtask
	task automatic run(input logic [7:0] b[$]);
		foreach (b[i])
			u_mem.load(b[i]);
		drain();
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (aux_we)
			n_aux_we++;
		if (timer_load)
			n_tld++;
		cyc++;
		if (cyc == 5000) begin
			errors++;
			$display("Error at %0t: timeout", $time);
			end_sim();
		end
	end

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		timer_overflow = 1'b0;
		slow = 1'b0;
		pointer_low_nibble = 4'h0;
		work_register = 4'h0;
		aux_in = 4'h0;
		standby_release_port = 4'h0;
		bus = '0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		tick(1);
		chk(port_out, {mie_pkg::NUM_PORTS*4{1'b1}});
		chk({fetch_ready, irq, control_register}, 6'h20);
		exp_port = '1;
		foreach (pl[j]) for (int b = 0; b < 4; b++) begin
			@(posedge core_clk);
			pointer_low_nibble <= pl[j];
			exp_port[4*pl[j]+b] = 1'b0;
			run({8'h24 | 8'(b)});
			chk({port_out, aux_out}, {exp_port, mie_pkg::AUX_CORRUPT});
			chk(zero_flag, exp_port[4*pl[j]+:4] == 4'h0);
		end
		$display("test port bits done");
		slow <= 1'b1;
		run({8'h2c, 8'h05});
		chk(control_register, 4'h5);
		run({8'h2c, 8'h0a});
		chk(control_register, 4'hf);
		run({8'h3c, 8'h06});
		chk({zero_flag, control_register}, 5'h09);
		run({8'h3c, 8'hf9});
		chk({zero_flag, control_register}, 5'h10);
		rd(mie_pkg::ADDR_CTL, 8'h00);
		slow <= 1'b0;
		run({8'h2c, 8'h03, 8'h00, 8'h00});
		chk({port_out, zero_flag, control_register}, {exp_port, 5'h13});
		@(posedge core_clk);
		clk_en <= 1'b0;
		u_mem.load(8'h2c);
		u_mem.load(8'h0c);
		tick(5);
		chk(control_register, 4'h3);
		clk_en <= 1'b1;
		drain();
		chk(control_register, 4'hf);
		$display("test control done");
		aux_in <= 4'ha;
		work_register <= 4'h5;
		wr(mie_pkg::ADDR_ENABLE, 8'h01);
		@(posedge core_clk);
		timer_overflow <= 1'b1;
		@(posedge core_clk);
		timer_overflow <= 1'b0;
		tick(2);
		chk({timer_overflow_flag, irq}, 2'b11);
		rd(mie_pkg::ADDR_STATUS, 8'h01);
		run({8'hfb});
		chk({count_value_register, timer_overflow_flag}, 9'h14a);
		rd(mie_pkg::ADDR_TIMER, 8'ha5);
		wr(mie_pkg::ADDR_ENABLE, 8'h00);
		chk(irq, 1'b0);
		wr(mie_pkg::ADDR_ENABLE, 8'h01);
		chk(irq, 1'b1);
		wr(mie_pkg::ADDR_CLEAR, 8'h01);
		chk(irq, 1'b0);
		rd(mie_pkg::ADDR_STATUS, 8'h00);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		rd(mie_pkg::ADDR_ENABLE, 8'h01);
		timer_overflow <= 1'b1;
		run({8'hfb});
		timer_overflow <= 1'b0;
		tick(1);
		chk({timer_overflow_flag, irq}, 2'b11);
		wr(mie_pkg::ADDR_CLEAR, 8'h01);
		chk(irq, 1'b0);
		$display("test timer done");
		run({8'hf6});
		chk({stopped, fetch_ready}, 2'b01);
		standby_release_port <= 4'h2;
		tick(4);
		run({8'hf6, 8'h3c, 8'h0f});
		chk({stopped, fetch_ready, control_register}, 6'h2f);
		rd(mie_pkg::ADDR_STATUS, 8'h02);
		chk(n_aux_we, 12);
		chk(n_tld, 2);
		$display("test stop done");
		end_sim();
	end
endmodule
